// ### hw/tw_pkg.sv
// Purpose: shared constants and types for the timer clock/clear/level control block
// Assumes: 32-bit apb, one aligned word per register
// Notes: byte offsets are local choices
package tw_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] TW_OFF_CTRL = 8'h00;
   localparam logic [7:0] TW_OFF_MODE = 8'h04;
   localparam logic [7:0] TW_OFF_CNT = 8'h08;
   // ==========================================================
   // reset values and field positions
   localparam logic [7:0] TW_CTRL_RST = 8'h00;
   localparam logic [15:0] TW_CNT_RST = 16'h0000;
   localparam int TW_MODE_START_BIT = 7;
   localparam logic [7:0] TW_MODE_RSVD_ONES = 8'h48;
   localparam int TW_CNT_W = 16;
   // ==========================================================
   // clock select codes
   localparam logic [2:0] TW_CKS_DIV1 = 3'h0;
   localparam logic [2:0] TW_CKS_DIV2 = 3'h1;
   localparam logic [2:0] TW_CKS_DIV4 = 3'h2;
   localparam logic [2:0] TW_CKS_DIV8 = 3'h3;

   typedef struct packed {
      logic clear_on_match_a;
      logic clock_select_bit2;
      logic clock_select_bit1;
      logic clock_select_bit0;
      logic initial_level_pin_d;
      logic initial_level_pin_c;
      logic initial_level_pin_b;
      logic level_pin_a;
   } tw_ctrl_t;

   typedef struct packed {
      logic match_a;
      logic match_b;
      logic match_c;
      logic match_d;
   } tw_match_t;
endpackage

// ### hw/tw_edge_sync.sv
// Purpose: two-flop synchroniser with rising edge pulse
// Assumes: async_in is from outside the pclk domain
// Notes: the first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module tw_edge_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   output logic rise
);
   logic meta;
   logic sync;
   logic sync_d;
   logic next_meta;
   logic next_sync;
   logic next_sync_d;

   // ==========================================================
   // synchroniser and edge detector
   always_comb begin
      next_meta = async_in;
      next_sync = meta;
      next_sync_d = sync;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         sync <= 1'b0;
         sync_d <= 1'b0;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         sync_d <= next_sync_d;
      end
   end

   // edge taken only from the settled copy
   assign rise = sync & ~sync_d;
endmodule // tw_edge_sync
`default_nettype wire

// ### hw/tw_timer_ctrl.sv
// Purpose: 16-bit timer counter with clock select, clear on match a and initial pin levels
// Assumes: match strobes are one-cycle pulses from pclk logic; event and subclock come from pins
// Notes: register access over apb, zero wait states
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tw_timer_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_event_input,
   input wire logic subclock_in,
   input wire logic low_power_mode,
   input wire tw_pkg::tw_match_t match,
   output logic compare_pin_b,
   output logic compare_pin_c,
   output logic compare_pin_d,
   output logic [tw_pkg::TW_CNT_W-1:0] timer_counter_value
);
   import tw_pkg::*;

   // ==========================================================
   // apb decode
   logic setup;
   logic access;
   logic hit;
   logic ctrl_wr;
   logic mode_wr;
   logic cnt_wr;
   tw_ctrl_t ctrl;
   tw_ctrl_t next_ctrl;
   logic start;
   logic next_start;
   logic [31:0] next_prdata;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == TW_OFF_CTRL) || (a == TW_OFF_MODE) || (a == TW_OFF_CNT);
   endfunction

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign hit = mapped(paddr);
   assign pready = access;
   assign pslverr = access & ~hit;
   assign ctrl_wr = access & pwrite & (paddr == TW_OFF_CTRL);
   assign mode_wr = access & pwrite & (paddr == TW_OFF_MODE);
   assign cnt_wr = access & pwrite & (paddr == TW_OFF_CNT);

   always_comb begin
      next_ctrl = ctrl;
      next_start = start;
      next_prdata = prdata;
      if (ctrl_wr) begin
         next_ctrl = tw_ctrl_t'(pwdata[7:0]);
      end
      if (mode_wr) begin
         next_start = pwdata[TW_MODE_START_BIT];
      end
      // read data is captured in setup so it comes from a flop in access
      if (setup) begin
         next_prdata = 32'h0000_0000;
         case (paddr)
            TW_OFF_CTRL: next_prdata[7:0] = ctrl;
            TW_OFF_MODE: next_prdata[7:0] = TW_MODE_RSVD_ONES | {start, 7'h00};
            TW_OFF_CNT: next_prdata[15:0] = timer_counter_value;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= tw_ctrl_t'(TW_CTRL_RST);
         start <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         start <= next_start;
         prdata <= next_prdata;
      end
   end

   // ==========================================================
   // clock source selection
   logic ext_rise;
   logic sub_rise;
   logic [2:0] presc;
   logic [2:0] next_presc;
   logic presc_tick;
   logic tick;
   logic [2:0] sel;

   // mask of prescaler bits that must all be one for a tick
   function automatic logic [2:0] div_mask(input logic [1:0] code);
      case (code)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   endfunction

   tw_edge_sync u_ext_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(external_event_input),
      .rise(ext_rise)
   );

   tw_edge_sync u_sub_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(subclock_in),
      .rise(sub_rise)
   );

   assign sel = {ctrl.clock_select_bit2, ctrl.clock_select_bit1, ctrl.clock_select_bit0};
   // free running divider; the first tick after a select change may come early
   assign next_presc = presc + 3'h1;
   assign presc_tick = (presc & div_mask(sel[1:0])) == div_mask(sel[1:0]);

   always_comb begin
      if (sel[2]) begin
         tick = ext_rise;
      end else if (low_power_mode) begin
         tick = sub_rise;
      end else begin
         tick = presc_tick;
      end
   end

   // ==========================================================
   // counter
   logic [TW_CNT_W-1:0] next_count;
   logic clr_a;

   assign clr_a = ctrl.clear_on_match_a & match.match_a;

   always_comb begin
      next_count = timer_counter_value;
      if (cnt_wr) begin
         next_count = pwdata[TW_CNT_W-1:0];
      end else if (clr_a) begin
         next_count = TW_CNT_RST;
      end else if (start && tick) begin
         next_count = timer_counter_value + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc <= 3'h0;
         timer_counter_value <= TW_CNT_RST;
      end else begin
         presc <= next_presc;
         timer_counter_value <= next_count;
      end
   end

   // ==========================================================
   // compare pin levels; a control write reloads levels, a match on b, c or d toggles that pin
   logic [2:0] pins;
   logic [2:0] next_pins;

   always_comb begin
      next_pins = pins;
      if (ctrl_wr) begin
         next_pins = {pwdata[3], pwdata[2], pwdata[1]};
      end else begin
         next_pins = pins ^ {match.match_d, match.match_c, match.match_b};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= 3'h0;
      end else begin
         pins <= next_pins;
      end
   end

   assign compare_pin_d = pins[2];
   assign compare_pin_c = pins[1];
   assign compare_pin_b = pins[0];

   // ==========================================================
   // checks
   logic quiet;
   assign quiet = ~cnt_wr & ~clr_a;

   a_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      clr_a && !cnt_wr |=> timer_counter_value == 16'h0000)
      else $error("counter not cleared by match a");

   a_free_run: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl.clear_on_match_a && !cnt_wr && start && tick && timer_counter_value == 16'hFFFF)
      |=> timer_counter_value == 16'h0000)
      else $error("counter did not wrap");

   a_div1_count: assert property (@(posedge pclk) disable iff (!presetn)
      (start && sel == TW_CKS_DIV1 && !low_power_mode && quiet)
      |=> timer_counter_value == $past(timer_counter_value) + 16'h0001)
      else $error("divide by one did not count");

   a_div2_gap: assert property (@(posedge pclk) disable iff (!presetn)
      (sel == TW_CKS_DIV2 && presc_tick) |=> (!presc_tick || sel != TW_CKS_DIV2))
      else $error("divide by two ticks too often");

   a_div8_gap: assert property (@(posedge pclk) disable iff (!presetn)
      (sel == TW_CKS_DIV8 && presc_tick) |=> (!presc_tick || sel != TW_CKS_DIV8)[*7])
      else $error("divide by eight ticks too often");

   a_ext_count: assert property (@(posedge pclk) disable iff (!presetn)
      (start && sel[2] && ext_rise && quiet)
      |=> timer_counter_value == $past(timer_counter_value) + 16'h0001)
      else $error("external edge not counted");

   a_sub_count: assert property (@(posedge pclk) disable iff (!presetn)
      (start && !sel[2] && low_power_mode && !sub_rise && quiet)
      |=> $stable(timer_counter_value))
      else $error("counted without subclock pulse");

   a_pin_d_init: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_wr ##1 (!match.match_d)[*2] |-> compare_pin_d == ctrl.initial_level_pin_d)
      else $error("pin d not at initial level");

   a_pin_c_init: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_wr |=> compare_pin_c == ctrl.initial_level_pin_c)
      else $error("pin c not at initial level");

   a_pin_b_init: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_wr |=> compare_pin_b == ctrl.initial_level_pin_b)
      else $error("pin b not at initial level");

   a_halt_stop: assert property (@(posedge pclk) disable iff (!presetn)
      (!start && quiet) |=> $stable(timer_counter_value))
      else $error("counter moved while halted");
endmodule // tw_timer_ctrl
`default_nettype wire

// ### tb/test_tw_timer_ctrl.sv
// Purpose: self-checking bench for the timer clock/clear/level control block
// Assumes: zero wait state apb slave; event and subclock pins run free from the bench
// Notes: count rates are measured as differences over fixed windows of 64 clocks
`timescale 1ns/1ps
`default_nettype none
module test_tw_timer_ctrl;
   import tw_pkg::*;
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] ctrl;
      logic lp;
      logic [15:0] delta;
   } tw_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, pin_b, pin_c, pin_d;
   logic ext_in = 1'b0, sub_in = 1'b0, lp = 1'b0;
   tw_match_t match = '0;
   logic [15:0] cnt_val, v1, d;
   logic [7:0] cyc = 8'h00;
   int bad_count = 0, num_checks = 0;
   // a window of 64 is a multiple of every period, so each delta is exact
   tw_row_t rows [8] = '{
      '{8'h80, 8'h00, 1'b0, 16'h0040},
      '{8'h80, 8'h10, 1'b0, 16'h0020},
      '{8'h80, 8'h20, 1'b0, 16'h0010},
      '{8'h80, 8'h30, 1'b0, 16'h0008},
      '{8'h80, 8'h40, 1'b0, 16'h0004},
      '{8'h80, 8'h70, 1'b1, 16'h0004},
      '{8'h80, 8'h00, 1'b1, 16'h0008},
      '{8'h00, 8'h00, 1'b0, 16'h0000}};
   // ==========================================
   // clock and free running pins
   always #12.5 pclk = ~pclk;
   // event period 16 clocks, subclock period 8, both well above the sync minimum
   always @(posedge pclk) begin
      cyc <= cyc + 8'h01;
      ext_in <= cyc[3];
      sub_in <= cyc[2];
   end
   tw_timer_ctrl u_tw_timer_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_event_input(ext_in), .subclock_in(sub_in),
      .low_power_mode(lp), .match(match), .compare_pin_b(pin_b), .compare_pin_c(pin_c),
      .compare_pin_d(pin_d), .timer_counter_value(cnt_val));
   // ==========================================
   // tasks
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
      output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait count assumed; only the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task measure(output logic [15:0] dd);
      apb(1'b0, TW_OFF_CNT, 32'h0, rd, err);
      v1 = rd[15:0];
      repeat (61) @(posedge pclk);
      apb(1'b0, TW_OFF_CNT, 32'h0, rd, err);
      dd = rd[15:0] - v1;
   endtask
   task pulse(input tw_match_t m);
      match <= m;
      @(posedge pclk);
      match <= '0;
      @(posedge pclk);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      give_verdict();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, TW_OFF_CTRL, 32'h0, rd, err);
      check("ctrl reset", {24'h0, TW_CTRL_RST}, rd);
      apb(1'b0, TW_OFF_MODE, 32'h0, rd, err);
      check("mode reset", 32'h00000048, rd);
      apb(1'b0, TW_OFF_CNT, 32'h0, rd, err);
      check("cnt reset", 32'h0, rd);
      check("pins reset", 32'h0, {29'h0, pin_d, pin_c, pin_b});
      check("pready idle", 32'h0, {31'h0, pready});
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, TW_OFF_MODE, {24'h0, rows[i].mode}, rd, err);
         apb(1'b1, TW_OFF_CTRL, {24'h0, rows[i].ctrl}, rd, err);
         lp <= rows[i].lp;
         repeat (8) @(posedge pclk);
         measure(d);
         check("count delta", {16'h0, rows[i].delta}, {16'h0, d});
      end
      lp <= 1'b0;
      apb(1'b1, TW_OFF_MODE, 32'h80, rd, err);
      apb(1'b0, TW_OFF_MODE, 32'h0, rd, err);
      check("mode start", 32'h000000C8, rd);
      apb(1'b1, TW_OFF_MODE, 32'h0, rd, err);
      apb(1'b1, TW_OFF_CTRL, 32'h80, rd, err);
      apb(1'b1, TW_OFF_CNT, 32'h1234, rd, err);
      pulse('{1'b1, 1'b0, 1'b0, 1'b0});
      apb(1'b0, TW_OFF_CNT, 32'h0, rd, err);
      check("cnt cleared", 32'h0, rd);
      apb(1'b1, TW_OFF_CNT, 32'h1234, rd, err);
      apb(1'b1, TW_OFF_CTRL, 32'h0, rd, err);
      pulse('{1'b1, 1'b0, 1'b0, 1'b0});
      apb(1'b0, TW_OFF_CNT, 32'h0, rd, err);
      check("cnt kept", 32'h1234, rd);
      check("cnt output", 32'h1234, {16'h0, cnt_val});
      apb(1'b1, TW_OFF_CNT, 32'hFFF8, rd, err);
      apb(1'b1, TW_OFF_MODE, 32'h80, rd, err);
      repeat (16) @(posedge pclk);
      apb(1'b0, TW_OFF_CNT, 32'h0, rd, err);
      check("cnt wrapped", 32'h1, {31'h0, rd < 32'h40});
      apb(1'b1, TW_OFF_MODE, 32'h0, rd, err);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, TW_OFF_CTRL, {28'h0, i[2:0], 1'b0}, rd, err);
         check("pin levels", {29'h0, i[2:0]}, {29'h0, pin_d, pin_c, pin_b});
      end
      apb(1'b1, TW_OFF_CTRL, 32'h0A, rd, err);
      pulse('{1'b0, 1'b1, 1'b0, 1'b0});
      check("pins after b", 32'h4, {29'h0, pin_d, pin_c, pin_b});
      pulse('{1'b0, 1'b0, 1'b1, 1'b0});
      check("pins after c", 32'h6, {29'h0, pin_d, pin_c, pin_b});
      pulse('{1'b0, 1'b0, 1'b0, 1'b1});
      check("pins after d", 32'h2, {29'h0, pin_d, pin_c, pin_b});
      apb(1'b1, TW_OFF_CTRL, 32'hFF, rd, err);
      apb(1'b1, 8'h10, 32'h0, rd, err);
      check("unmapped write err", 32'h1, {31'h0, err});
      apb(1'b0, 8'h0C, 32'h0, rd, err);
      check("unmapped read err", 32'h1, {31'h0, err});
      check("unmapped read data", 32'h0, rd);
      apb(1'b0, TW_OFF_CTRL, 32'h0, rd, err);
      check("ctrl readback", 32'hFF, rd);
      // a second reset mid-run must bring the control word back to zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, TW_OFF_CTRL, 32'h0, rd, err);
      check("ctrl after reset", 32'h0, rd);
      check("cnt after reset", 32'h0, {16'h0, cnt_val});
      check("pins after reset", 32'h0, {29'h0, pin_d, pin_c, pin_b});
      give_verdict();
   end
endmodule // test_tw_timer_ctrl
`default_nettype wire
